// ==== alarm_pkg.sv ====
package alarm_pkg;

  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned LED_PULSE_MS     = 250;
  localparam int unsigned LED_PULSE_CYCLES = CLK_HZ / 1000 * LED_PULSE_MS;
  localparam logic [2:0]  LED_GAP_PULSES   = 3'h4;

  // Consecutive-error limits and request length bounds
  localparam logic [2:0]  EXC_LIMIT        = 3'h5;
  localparam logic [2:0]  TX_LIMIT         = 3'h3;
  localparam logic [2:0]  RX_LIMIT         = 3'h3;
  localparam logic [9:0]  RX_LEN_MAX       = 10'h100;
  localparam logic [9:0]  RX_LEN_MIN       = 10'h004;

  // Relay count limits per relay type
  localparam logic [7:0]  LIMIT_STD        = 8'h30;
  localparam logic [7:0]  LIMIT_CM         = 8'h20;

  localparam logic [2:0]  ABSENT_HALF_MAX  = 3'h3;
  localparam logic [31:0] PCT_SCALE        = 32'h0000_0064;

  // Relay alarm word bit positions
  localparam int unsigned AL_SYS1     = 0;
  localparam int unsigned AL_SYS2     = 1;
  localparam int unsigned AL_SHORT    = 2;
  localparam int unsigned AL_VOLT     = 3;
  localparam int unsigned AL_CURR     = 4;
  localparam int unsigned AL_FREQ     = 5;
  localparam int unsigned AL_PREWARN  = 6;
  localparam int unsigned AL_OVERTEMP = 7;
  localparam int unsigned AL_LOADDEV  = 8;

  // Flash counts per alarm
  localparam logic [2:0]  FLASH_LOADDEV = 3'h1;
  localparam logic [2:0]  FLASH_SYS1    = 3'h2;
  localparam logic [2:0]  FLASH_SYS2    = 3'h3;
  localparam logic [2:0]  FLASH_SHORT   = 3'h4;
  localparam logic [2:0]  FLASH_FREQ    = 3'h5;
  localparam logic [2:0]  FLASH_CURR    = 3'h6;
  localparam logic [2:0]  FLASH_VOLT    = 3'h7;

  // Register byte offsets
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_CONTROL  = 8'h04;
  localparam logic [7:0]  OFS_COUNTERS = 8'h08;
  localparam logic [7:0]  OFS_ALARM1   = 8'h0C;
  localparam logic [7:0]  OFS_GENERAL  = 8'h10;
  localparam logic [7:0]  OFS_REFCUR   = 8'h14;
  localparam logic [7:0]  OFS_DEVPCT   = 8'h18;

  // Controller status bits
  localparam int unsigned ST_COMM     = 0;
  localparam int unsigned ST_LIMIT    = 1;
  localparam int unsigned ST_MISMATCH = 2;
  localparam int unsigned ST_TERM     = 3;
  localparam int unsigned ST_INTERNAL = 4;
  localparam int unsigned ST_BUSALARM = 5;

  // Control bits
  localparam int unsigned CT_MISMATCH = 0;
  localparam int unsigned CT_CM_TYPE  = 1;
  localparam int unsigned CT_CLR_INT  = 2;

  typedef struct packed {
    logic valid;
    logic exception;
    logic collision;
  } reply_t;

  typedef struct packed {
    logic       valid;
    logic       byte_err;
    logic       crc_err;
    logic       gap_err;
    logic [9:0] length;
  } request_t;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_ON   = 2'b01,
    FL_OFF  = 2'b10,
    FL_GAP  = 2'b11
  } flash_state_t;

endpackage

// ==== led_flasher.sv ====
`timescale 1ns/10ps
`default_nettype none
module led_flasher
  import alarm_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = LED_PULSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       steady,
  input  wire logic [2:0] count,
  output logic            led
);

  flash_state_t state;
  logic [23:0]  timer;
  logic [2:0]   left;
  logic         tick;

  assign tick = (timer == 24'(PULSE_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!resetn || state == FL_IDLE || tick) begin
      timer <= 24'h000000;
    end else begin
      timer <= timer + 24'h000001;
    end
  end

  // One burst of count pulses, then a dark gap; repeats
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= FL_IDLE;
      left  <= 3'h0;
      led   <= 1'b0;
    end else begin
      case (state)
        FL_IDLE: begin
          led <= steady;
          if (!steady && count != 3'h0) begin
            state <= FL_ON;
            left  <= count;
            led   <= 1'b1;
          end
        end
        FL_ON: begin
          if (steady) begin
            state <= FL_IDLE;
          end else if (tick) begin
            state <= FL_OFF;
            led   <= 1'b0;
          end
        end
        FL_OFF: begin
          if (steady) begin
            state <= FL_IDLE;
          end else if (tick) begin
            if (left > 3'h1) begin
              left  <= left - 3'h1;
              state <= FL_ON;
              led   <= 1'b1;
            end else begin
              left  <= LED_GAP_PULSES;
              state <= FL_GAP;
            end
          end
        end
        FL_GAP: begin
          if (steady) begin
            state <= FL_IDLE;
          end else if (tick) begin
            if (left > 3'h1) begin
              left <= left - 3'h1;
            end else begin
              state <= FL_IDLE;
            end
          end
        end
        default: begin
          state <= FL_IDLE;
        end
      endcase
    end
  end

endmodule // led_flasher
`default_nettype wire

// ==== alarm_monitor.sv ====
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE_01] After roll call, flag limit alarm if relays exceed 48 standard or 32 monitoring.
// [RULE_02] Mismatch alarm comes only from the host via a dedicated command.
// [RULE_03] Count consecutive exception replies; communication alarm at 5.
// [RULE_04] A positive reply zeroes the exception counter.
// [RULE_05] Count consecutive replies with collision; communication alarm at 3.
// [RULE_06] A reply sent without collision zeroes the transmit counter.
// [RULE_07] Count consecutive faulty requests (framing, parity, overflow); alarm at 3.
// [RULE_08] Requests over 256 or under 4 bytes count as reception errors.
// [RULE_09] Requests with a bad CRC count as reception errors.
// [RULE_10] Bytes arriving between 1.5 and 3.5 character gaps count as errors.
// [RULE_11] An error-free request zeroes the reception counter.
// [RULE_12] Communication alarm clears once no counter sits at its limit.
// [RULE_13] Start relay transactions only when a host request needs them.
// [RULE_14] Downstream bus alarm is never raised from relay link errors.
// [RULE_15] Internal fault shows in controller status; operation continues.
// [RULE_16] Termination checked only at power-up; failure sets termination flag.
// [RULE_17] Termination flag stays set until power cycle with a good check.
// [RULE_18] Relay alarm word holds the nine alarm flags in bits 0 to 8.
// [RULE_19] Over-temperature sets flags, lights LED steadily, forces output off.
// [RULE_20] After cooling the output follows the control input again.
// [RULE_21] Load deviation beyond percentage, not voltage caused, flags and flashes once.
// [RULE_22] Signals absent over 3 half cycles: system fault one, flash twice.
// [RULE_23] All applicable flags set; LED shows highest-priority alarm pattern.
// [RULE_24] Load not on within a half cycle under control: fault two, three flashes.
// [RULE_25] Error counters saturate at their limit until their own clearing event.
// [RULE_26] LED repeats one burst per period with pulses equal to flash count.
module alarm_monitor
  import alarm_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = LED_PULSE_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire reply_t      HOST_REPLY,
  input  wire request_t    HOST_REQUEST,
  input  wire logic        ROLL_DONE,
  input  wire logic [7:0]  ROLL_COUNT,
  input  wire logic        INTERNAL_FAULT,
  input  wire logic        TERM_OK,
  input  wire logic        HOST_NEEDS_RELAY,
  input  wire logic        RELAY_TXN_REQ,
  input  wire logic        OVER_TEMP,
  input  wire logic        PREWARN,
  input  wire logic        SHORT_CIRCUIT,
  input  wire logic        VOLT_RANGE,
  input  wire logic        CURR_RANGE,
  input  wire logic        FREQ_RANGE,
  input  wire logic        CONTROL_IN,
  input  wire logic        LOAD_ON,
  input  wire logic        HALF_CYCLE,
  input  wire logic        SIGNAL_ABSENT,
  input  wire logic [15:0] LOAD_CURRENT,
  input  wire logic        VOLTAGE_CHANGED,
  output logic             COMM_ALARM,
  output logic             TERM_FAULT,
  output logic             RELAY_TXN_START,
  output logic             RELAY_OUT,
  output logic             ALARM_LED
);

  logic [2:0]  exc_cnt;
  logic [2:0]  tx_cnt;
  logic [2:0]  rx_cnt;
  logic        limit_alarm;
  logic        internal_fault;
  logic        term_checked;
  logic [2:0]  control;
  logic [15:0] reference_current_value;
  logic [7:0]  deviation_percent_limit;
  logic [15:0] relay_alarm_status_one;
  logic        alarm_summary_flag;
  logic [2:0]  absent_cnt;
  logic        rx_bad;
  logic        apb_access;
  logic        apb_write;
  logic        next_ready;
  logic        hit;
  logic [31:0] rword;
  logic [15:0] cur_diff;
  logic        deviates;
  logic        led_steady;
  logic [2:0]  led_count;

  // Reply counters, saturating at their limit
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      exc_cnt <= 3'h0;
    end else if (HOST_REPLY.valid) begin
      if (!HOST_REPLY.exception) begin
        exc_cnt <= 3'h0; // [RULE_04]
      end else if (exc_cnt != EXC_LIMIT) begin
        exc_cnt <= exc_cnt + 3'h1; // [RULE_03] [RULE_25]
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tx_cnt <= 3'h0;
    end else if (HOST_REPLY.valid) begin
      if (!HOST_REPLY.collision) begin
        tx_cnt <= 3'h0; // [RULE_06]
      end else if (tx_cnt != TX_LIMIT) begin
        tx_cnt <= tx_cnt + 3'h1; // [RULE_05] [RULE_25]
      end
    end
  end

  assign rx_bad = HOST_REQUEST.byte_err // [RULE_07]
                | HOST_REQUEST.crc_err // [RULE_09]
                | HOST_REQUEST.gap_err // [RULE_10]
                | (HOST_REQUEST.length > RX_LEN_MAX) // [RULE_08]
                | (HOST_REQUEST.length < RX_LEN_MIN); // [RULE_08]

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rx_cnt <= 3'h0;
    end else if (HOST_REQUEST.valid) begin
      if (!rx_bad) begin
        rx_cnt <= 3'h0; // [RULE_11]
      end else if (rx_cnt != RX_LIMIT) begin
        rx_cnt <= rx_cnt + 3'h1; // [RULE_07] [RULE_25]
      end
    end
  end

  // Alarm lags its counters by one cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      COMM_ALARM <= 1'b0;
    end else begin
      COMM_ALARM <= (exc_cnt == EXC_LIMIT) | (tx_cnt == TX_LIMIT)
                  | (rx_cnt == RX_LIMIT); // [RULE_03] [RULE_05] [RULE_07] [RULE_12]
    end
  end

  // Judged afresh at every roll call
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      limit_alarm <= 1'b0;
    end else if (ROLL_DONE) begin
      limit_alarm <= ROLL_COUNT > (control[CT_CM_TYPE] ? LIMIT_CM : LIMIT_STD); // [RULE_01]
    end
  end

  // Sticky; a new fault beats a simultaneous clear
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      internal_fault <= 1'b0;
    end else if (INTERNAL_FAULT) begin
      internal_fault <= 1'b1; // [RULE_15]
    end else if (apb_write && PADDR == OFS_CONTROL && PWDATA[CT_CLR_INT]) begin
      internal_fault <= 1'b0;
    end
  end

  // Reset stands for power-up; only reset can clear the flag
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      term_checked <= 1'b0;
      TERM_FAULT   <= 1'b0;
    end else if (!term_checked) begin
      term_checked <= 1'b1;
      TERM_FAULT   <= !TERM_OK; // [RULE_16] [RULE_17]
    end
  end

  // Never self-initiated toward the relays
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RELAY_TXN_START <= 1'b0;
    end else begin
      RELAY_TXN_START <= RELAY_TXN_REQ && HOST_NEEDS_RELAY; // [RULE_13]
    end
  end

  // Relay-side alarms
  assign cur_diff = (LOAD_CURRENT > reference_current_value)
                  ? LOAD_CURRENT - reference_current_value
                  : reference_current_value - LOAD_CURRENT;
  assign deviates = (reference_current_value != 16'h0000) && !VOLTAGE_CHANGED
                 && ({16'h0000, cur_diff} * PCT_SCALE >
                     {24'h000000, deviation_percent_limit} * {16'h0000, reference_current_value});

  always_ff @(posedge CLK) begin
    if (!RESETN || !SIGNAL_ABSENT) begin
      absent_cnt <= 3'h0;
    end else if (HALF_CYCLE && absent_cnt <= ABSENT_HALF_MAX) begin
      absent_cnt <= absent_cnt + 3'h1; // [RULE_22]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      relay_alarm_status_one <= 16'h0000;
    end else begin
      relay_alarm_status_one[AL_SYS1]     <= absent_cnt > ABSENT_HALF_MAX; // [RULE_22]
      if (HALF_CYCLE) begin
        relay_alarm_status_one[AL_SYS2]   <= CONTROL_IN && !LOAD_ON; // [RULE_24]
      end
      relay_alarm_status_one[AL_SHORT]    <= SHORT_CIRCUIT; // [RULE_18]
      relay_alarm_status_one[AL_VOLT]     <= VOLT_RANGE;
      relay_alarm_status_one[AL_CURR]     <= CURR_RANGE;
      relay_alarm_status_one[AL_FREQ]     <= FREQ_RANGE;
      relay_alarm_status_one[AL_PREWARN]  <= PREWARN;
      relay_alarm_status_one[AL_OVERTEMP] <= OVER_TEMP; // [RULE_19]
      relay_alarm_status_one[AL_LOADDEV]  <= deviates; // [RULE_21]
    end
  end

  // Pre-warning is not an alarm, so it stays out of the summary
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      alarm_summary_flag <= 1'b0;
    end else begin
      alarm_summary_flag <= |(relay_alarm_status_one & ~(16'h0001 << AL_PREWARN)); // [RULE_23]
    end
  end

  // Load deviation leaves switching untouched
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RELAY_OUT <= 1'b0;
    end else begin
      RELAY_OUT <= CONTROL_IN && !OVER_TEMP; // [RULE_19] [RULE_20] [RULE_21]
    end
  end

  // LED priority: highest active alarm wins
  always_comb begin
    led_steady = relay_alarm_status_one[AL_OVERTEMP]; // [RULE_19]
    if (relay_alarm_status_one[AL_SYS1]) begin
      led_count = FLASH_SYS1; // [RULE_23]
    end else if (relay_alarm_status_one[AL_SYS2]) begin
      led_count = FLASH_SYS2;
    end else if (relay_alarm_status_one[AL_SHORT]) begin
      led_count = FLASH_SHORT;
    end else if (relay_alarm_status_one[AL_FREQ]) begin
      led_count = FLASH_FREQ;
    end else if (relay_alarm_status_one[AL_CURR]) begin
      led_count = FLASH_CURR;
    end else if (relay_alarm_status_one[AL_VOLT]) begin
      led_count = FLASH_VOLT;
    end else if (relay_alarm_status_one[AL_LOADDEV]) begin
      led_count = FLASH_LOADDEV; // [RULE_21]
    end else begin
      led_count = 3'h0;
    end
  end

  led_flasher #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_flasher (
    .clk    (CLK),
    .resetn (RESETN),
    .steady (led_steady),
    .count  (led_count),
    .led    (ALARM_LED) // [RULE_26]
  );

  // APB slave with one wait state
  assign apb_access = PSEL && PENABLE;
  assign apb_write  = apb_access && PREADY && PWRITE;
  assign next_ready = apb_access && !PREADY;

  always_comb begin
    hit   = 1'b1;
    rword = 32'h0000_0000;
    case (PADDR)
      OFS_STATUS: begin
        rword[ST_COMM]     = COMM_ALARM;
        rword[ST_LIMIT]    = limit_alarm;
        rword[ST_MISMATCH] = control[CT_MISMATCH]; // [RULE_02]
        rword[ST_TERM]     = TERM_FAULT;
        rword[ST_INTERNAL] = internal_fault; // [RULE_15]
        rword[ST_BUSALARM] = 1'b0; // [RULE_14]
      end
      OFS_CONTROL:  rword = {29'h0, 1'b0, control[CT_CM_TYPE], control[CT_MISMATCH]};
      OFS_COUNTERS: rword = {20'h0, 1'b0, rx_cnt, 1'b0, tx_cnt, 1'b0, exc_cnt};
      OFS_ALARM1:   rword = {16'h0000, relay_alarm_status_one};
      OFS_GENERAL:  rword = {31'h0, alarm_summary_flag};
      OFS_REFCUR:   rword = {16'h0000, reference_current_value};
      OFS_DEVPCT:   rword = {24'h000000, deviation_percent_limit};
      default:      hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= next_ready;
      PSLVERR <= next_ready && !hit;
      if (next_ready && !PWRITE) begin
        PRDATA <= rword;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      control                 <= 3'h0;
      reference_current_value <= 16'h0000;
      deviation_percent_limit <= 8'h00;
    end else if (apb_write) begin
      case (PADDR)
        OFS_CONTROL: begin
          control[CT_MISMATCH] <= PWDATA[CT_MISMATCH]; // [RULE_02]
          control[CT_CM_TYPE]  <= PWDATA[CT_CM_TYPE];
        end
        OFS_REFCUR:  reference_current_value <= PWDATA[15:0];
        OFS_DEVPCT:  deviation_percent_limit <= PWDATA[7:0];
        default:     control <= control;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_fifth_exception;
    HOST_REPLY.valid && HOST_REPLY.exception && exc_cnt == 3'h4;
  endsequence

  sequence s_alarm_follows;
    exc_cnt == EXC_LIMIT ##1 COMM_ALARM;
  endsequence

  a_exc_alarm_raise: assert property (s_fifth_exception |=> s_alarm_follows) // [RULE_03]
    else $error("exception limit did not raise alarm");

  a_exc_positive_clear: assert property (HOST_REPLY.valid && !HOST_REPLY.exception
                                         |=> exc_cnt == 3'h0) // [RULE_04]
    else $error("positive reply did not clear exception count");

  a_tx_collision_alarm: assert property (HOST_REPLY.valid && HOST_REPLY.collision
                                         && tx_cnt == 3'h2 |=> ##1 COMM_ALARM) // [RULE_05]
    else $error("third collision did not raise alarm");

  a_rx_length_count: assert property (HOST_REQUEST.valid && HOST_REQUEST.length > RX_LEN_MAX
                                      && rx_cnt == 3'h0 |=> rx_cnt == 3'h1) // [RULE_08]
    else $error("long request not counted");

  a_rx_good_clear: assert property (HOST_REQUEST.valid && !rx_bad |=> rx_cnt == 3'h0) // [RULE_11]
    else $error("good request did not clear reception count");

  a_counter_saturates: assert property (exc_cnt <= EXC_LIMIT && tx_cnt <= TX_LIMIT
                                        && rx_cnt <= RX_LIMIT) // [RULE_25]
    else $error("counter passed its limit");

  a_alarm_clears: assert property (exc_cnt != EXC_LIMIT && tx_cnt != TX_LIMIT
                                   && rx_cnt != RX_LIMIT |=> !COMM_ALARM) // [RULE_12]
    else $error("alarm held without a counter at limit");

  a_limit_standard: assert property (ROLL_DONE && !control[CT_CM_TYPE] && ROLL_COUNT == 8'h31
                                     |=> limit_alarm) // [RULE_01]
    else $error("49 standard relays not flagged");

  a_relay_start_gate: assert property (RELAY_TXN_START |-> $past(HOST_NEEDS_RELAY)) // [RULE_13]
    else $error("relay transaction without host need");

  a_term_sticky: assert property (TERM_FAULT |=> TERM_FAULT) // [RULE_17]
    else $error("termination flag cleared without reset");

  a_overtemp_off: assert property (OVER_TEMP |=> !RELAY_OUT && led_steady) // [RULE_19]
    else $error("over-temperature did not force output off");

  a_recover_follow: assert property (RESETN && !OVER_TEMP && CONTROL_IN |=> RELAY_OUT) // [RULE_20]
    else $error("output did not follow control after cooling");

  a_absent_fault: assert property (SIGNAL_ABSENT && HALF_CYCLE && absent_cnt == ABSENT_HALF_MAX
                                   |=> ##1 relay_alarm_status_one[AL_SYS1]) // [RULE_22]
    else $error("absent signals did not raise fault one");

endmodule // alarm_monitor
`default_nettype wire

// ==== host_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_link_model
  import alarm_pkg::*;
(
  input  wire logic clk,
  output var reply_t   rep,
  output var request_t req
);
  initial begin
    rep = '0;
    req = '0;
  end
  // One frame is one valid cycle; frames never merge into a level
  task automatic reply(input logic exc, input logic col);
    @(posedge clk);
    rep <= '{valid: 1'b1, exception: exc, collision: col};
    @(posedge clk);
    rep <= '0;
  endtask
  task automatic request(input logic [2:0] errs, input logic [9:0] len);
    @(posedge clk);
    req <= '{1'b1, errs[2], errs[1], errs[0], len};
    @(posedge clk);
    req <= '0;
  endtask
endmodule // host_link_model
`default_nettype wire

// ==== bus_controller_alarm_monitor_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module bus_controller_alarm_monitor_tb;
  import alarm_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, roll_count = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, rerr, comm_alarm, term_fault, txn_start, relay_out, led;
  logic roll_done = 0, int_fault = 0, term_ok = 0, needs = 0, txn_req = 0;
  logic ctl = 0, load_on = 0, half = 0, absent = 0, vchg = 0;
  logic [5:0]  lv = '0;
  logic [15:0] cur = '0;
  reply_t      rep;
  request_t    req;
  int error_cnt = 0;
  int checked = 0;
  always #10 clk = ~clk;
  host_link_model host_u (.clk(clk), .rep(rep), .req(req));
  alarm_monitor #(.PULSE_CYCLES(4)) dut_u (
    .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HOST_REPLY(rep), .HOST_REQUEST(req), .ROLL_DONE(roll_done), .ROLL_COUNT(roll_count),
    .INTERNAL_FAULT(int_fault), .TERM_OK(term_ok), .HOST_NEEDS_RELAY(needs),
    .RELAY_TXN_REQ(txn_req), .OVER_TEMP(lv[0]), .PREWARN(lv[1]), .SHORT_CIRCUIT(lv[2]),
    .VOLT_RANGE(lv[3]), .CURR_RANGE(lv[4]), .FREQ_RANGE(lv[5]), .CONTROL_IN(ctl),
    .LOAD_ON(load_on), .HALF_CYCLE(half), .SIGNAL_ABSENT(absent), .LOAD_CURRENT(cur),
    .VOLTAGE_CHANGED(vchg), .COMM_ALARM(comm_alarm), .TERM_FAULT(term_fault),
    .RELAY_TXN_START(txn_start), .RELAY_OUT(relay_out), .ALARM_LED(led));
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse_half;
    @(posedge clk);
    half <= 1'b1;
    @(posedge clk);
    half <= 1'b0;
    tick(2);
  endtask
  task automatic roll(input logic [7:0] cnt, input logic exp);
    @(posedge clk);
    roll_done <= 1'b1;
    roll_count <= cnt;
    @(posedge clk);
    roll_done <= 1'b0;
    apb(1'b0, OFS_STATUS, '0);
    chk(rdata[ST_LIMIT], exp);
  endtask
  task automatic t_link;
    logic [12:0] bad [5];
    bad = '{{3'b100, 10'd10}, {3'b010, 10'd10}, {3'b001, 10'd10},
            {3'b000, 10'd257}, {3'b000, 10'd3}};
    for (int i = 1; i <= 6; i++) begin
      host_u.reply(1'b1, 1'b0);
      tick(2);
      chk(comm_alarm, i >= 5);
    end
    apb(1'b0, OFS_COUNTERS, '0);
    chk(rdata[2:0], EXC_LIMIT);
    host_u.reply(1'b0, 1'b0);
    tick(2);
    chk(comm_alarm, 0);
    for (int i = 1; i <= 3; i++) begin
      host_u.reply(1'b0, 1'b1);
      tick(2);
      chk(comm_alarm, i >= 3);
    end
    host_u.reply(1'b1, 1'b0);
    tick(2);
    chk(comm_alarm, 0);
    for (int k = 0; k < 5; k++) begin
      repeat (3) host_u.request(bad[k][12:10], bad[k][9:0]);
      tick(2);
      chk(comm_alarm, 1);
      host_u.request(3'b000, k[0] ? 10'd4 : 10'd256);
      tick(2);
      chk(comm_alarm, 0);
    end
  endtask
  task automatic t_host_regs;
    apb(1'b0, 8'h40, '0);
    chk(rerr, 1);
    chk(rdata, 0);
    apb(1'b1, OFS_CONTROL, 32'h0);
    roll(8'd48, 1'b0);
    roll(8'd49, 1'b1);
    apb(1'b1, OFS_CONTROL, 32'h2);
    roll(8'd33, 1'b1);
    roll(8'd32, 1'b0);
    apb(1'b1, OFS_CONTROL, 32'h1);
    apb(1'b0, OFS_STATUS, '0);
    chk(rdata[ST_MISMATCH], 1);
    @(posedge clk);
    int_fault <= 1'b1;
    txn_req <= 1'b1;
    @(posedge clk);
    int_fault <= 1'b0;
    txn_req <= 1'b0;
    @(posedge clk);
    chk(txn_start, 0);
    apb(1'b0, OFS_STATUS, '0);
    chk(rdata[ST_INTERNAL], 1);
    chk(rdata[ST_BUSALARM], 0);
    apb(1'b1, OFS_CONTROL, 32'h4);
    apb(1'b0, OFS_STATUS, '0);
    chk(rdata[ST_INTERNAL], 0);
    needs <= 1'b1;
    txn_req <= 1'b1;
    @(posedge clk);
    txn_req <= 1'b0;
    @(posedge clk);
    chk(txn_start, 1);
  endtask
  task automatic t_relay;
    int unsigned pos [6];
    int n;
    logic prev;
    pos = '{AL_OVERTEMP, AL_PREWARN, AL_SHORT, AL_VOLT, AL_CURR, AL_FREQ};
    for (int i = 0; i < 6; i++) begin
      lv <= 6'(1 << i);
      apb(1'b0, OFS_ALARM1, '0);
      chk(rdata, 32'h1 << pos[i]);
      apb(1'b0, OFS_GENERAL, '0);
      chk(rdata[0], i != 1);
    end
    ctl <= 1'b1;
    load_on <= 1'b1;
    lv <= 6'h01;
    tick(3);
    chk(relay_out, 0);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += int'(led === 1'b1);
    end
    chk(n, 20);
    lv <= 6'h00;
    tick(3);
    chk(relay_out, 1);
    load_on <= 1'b0;
    pulse_half();
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h2);
    tick(50);
    n = 0;
    prev = led;
    repeat (41) begin
      @(posedge clk);
      n += int'(led === 1'b1 && prev === 1'b0);
      prev = led;
    end
    chk(n, FLASH_SYS2);
    load_on <= 1'b1;
    pulse_half();
    apb(1'b1, OFS_REFCUR, 32'h64);
    apb(1'b1, OFS_DEVPCT, 32'h0A);
    cur <= 16'h006E;
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h0);
    cur <= 16'h0070;
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h100);
    vchg <= 1'b1;
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h0);
    absent <= 1'b1;
    repeat (3) pulse_half();
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h0);
    pulse_half();
    apb(1'b0, OFS_ALARM1, '0);
    chk(rdata, 32'h1);
  endtask
  initial begin
    tick(8);
    resetn <= 1'b1;
    tick(2);
    chk(term_fault, 1);
    term_ok <= 1'b1;
    t_link();
    t_host_regs();
    t_relay();
    chk(term_fault, 1);
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(2);
    chk(term_fault, 0);
    finish_test();
  end
endmodule // bus_controller_alarm_monitor_tb
`default_nettype wire
